// file: logic/gauge_pkg.sv
/*
 Shared constants for the gauge register bank: slave address, bus timing,
 register byte addresses, reset values and the serial engine state encoding.
 Assumes a 25 MHz system clock and a host that is the only bus master.
*/
package gauge_pkg;

	localparam logic [6:0]  DEVICE_ADDR      = 7'h55;
	localparam int          BUS_KBPS         = 400;
	localparam int          SYS_CLK_KHZ      = 25000;
	localparam int          BIT_CYCLES       = SYS_CLK_KHZ / BUS_KBPS;
	localparam int          WORD_COUNT       = 52;
	localparam logic [3:0]  BITS_PER_BYTE    = 4'h8;
	localparam logic [15:0] QUICK_SENSE_CMD  = 16'h4000;

	localparam logic [6:0]  A_MAIN_CONTROL   = 7'h00;
	localparam logic [6:0]  A_SENSED_AMP     = 7'h04;
	localparam logic [6:0]  A_THERMAL        = 7'h06;
	localparam logic [6:0]  A_CELL_VOLTAGE   = 7'h08;
	localparam logic [6:0]  A_STATUS_ONE     = 7'h0A;
	localparam logic [6:0]  A_STATUS_TWO     = 7'h0C;
	localparam logic [6:0]  A_REMAINING      = 7'h10;
	localparam logic [6:0]  A_FULL_CHARGE    = 7'h12;
	localparam logic [6:0]  A_MEAN_AMP       = 7'h14;
	localparam logic [6:0]  A_TIME_TO_EMPTY  = 7'h16;
	localparam logic [6:0]  A_REVISION       = 7'h20;
	localparam logic [6:0]  A_TUNING_A       = 7'h24;
	localparam logic [6:0]  A_TUNING_B       = 7'h26;
	localparam logic [6:0]  A_DIE_THERMAL    = 7'h28;
	localparam logic [6:0]  A_CYCLE_TALLY    = 7'h2A;
	localparam logic [6:0]  A_CHARGE_PCT     = 7'h2C;
	localparam logic [6:0]  A_HEALTH_PCT     = 7'h2E;
	localparam logic [6:0]  A_STATUS_THREE   = 7'h30;
	localparam logic [6:0]  A_IRQ_STATUS     = 7'h36;
	localparam logic [6:0]  A_DESIGN_CAP     = 7'h3C;
	localparam logic [6:0]  A_EXT_CONTROL    = 7'h3E;
	localparam logic [6:0]  A_MEAN_VOLTAGE   = 7'h64;
	localparam logic [6:0]  A_MEAN_THERMAL   = 7'h66;

	localparam logic [15:0] R_ZERO           = 16'h0000;
	localparam logic [15:0] R_THERMAL        = 16'h0BA6;
	localparam logic [15:0] R_VOLTAGE        = 16'h0ED8;
	localparam logic [15:0] R_REMAINING      = 16'h03CF;
	localparam logic [15:0] R_CAPACITY       = 16'h079E;
	localparam logic [15:0] R_TIME_TO_EMPTY  = 16'hFFFF;
	localparam logic [15:0] R_TUNING         = 16'h3232;
	localparam logic [15:0] R_CHARGE_PCT     = 16'h0021;
	localparam logic [15:0] R_HEALTH_PCT     = 16'h0064;
	// arbitrary revision code, not tied to any part
	localparam logic [15:0] R_REVISION       = 16'h00A5;

	typedef enum logic [2:0] {
		LS_IDLE  = 3'h0,
		LS_ADDR  = 3'h1,
		LS_ACKA  = 3'h3,
		LS_WRITE = 3'h2,
		LS_ACKW  = 3'h6,
		LS_READ  = 3'h7,
		LS_RACK  = 3'h5
	} link_state_t;

endpackage : gauge_pkg

// file: logic/gauge_link_if.sv
/*
 Byte-level carrier between the serial engine and the register bank.
 Assumes both ends share sys_clk; all strobes are one-cycle pulses.
*/
`timescale 1ns/100ps
interface gauge_link_if;
	logic       startSeen;
	logic       wrByte;
	logic       wrFirst;
	logic [7:0] wrData;
	logic       rdReq;
	logic [7:0] rdData;

	modport link (output startSeen, output wrByte, output wrFirst, output wrData, output rdReq, input rdData);
	modport bank (input startSeen, input wrByte, input wrFirst, input wrData, input rdReq, output rdData);
endinterface : gauge_link_if

// file: logic/i2c_link.sv
/*
 Serial slave engine: start/stop detection, address match, byte shifting and
 acknowledge. Assumes scl and sdaIn are already synchronous to sys_clk and the
 bank answers a read request long before the next scl fall.
*/
`timescale 1ns/100ps
module i2c_link (
	input  wire logic  sys_clk,
	input  wire logic  rstN,
	input  wire logic  scl,
	input  wire logic  sdaIn,
	output logic       sdaOut,
	output logic       sdaOeN,
	gauge_link_if.link bus
);

	typedef struct packed {
		gauge_pkg::link_state_t state;
		logic                   sclQ;
		logic                   sdaQ;
		logic [7:0]             shift;
		logic [3:0]             cnt;
		logic                   rw;
		logic                   first;
		logic                   oeN;
		logic                   rdReq;
		logic                   wrByte;
		logic                   wrFirst;
		logic                   startSeen;
	} link_t;

	link_t s_reg;
	link_t s_next;
	logic  sclRise;
	logic  sclFall;
	logic  startCond;
	logic  stopCond;

	////////////////////////////////////////////////////////////////////////
	// oversampled at many clocks per bit, so plain edge compare is enough
	assign sclRise   = scl & ~s_reg.sclQ;
	assign sclFall   = ~scl & s_reg.sclQ;
	assign startCond = s_reg.sclQ & scl & s_reg.sdaQ & ~sdaIn;
	assign stopCond  = s_reg.sclQ & scl & ~s_reg.sdaQ & sdaIn;

	always_comb
	begin
		s_next           = s_reg;
		s_next.sclQ      = scl;
		s_next.sdaQ      = sdaIn;
		s_next.rdReq     = 1'b0;
		s_next.wrByte    = 1'b0;
		s_next.startSeen = 1'b0;
		if (startCond)
		begin
			s_next.state     = gauge_pkg::LS_ADDR;
			s_next.cnt       = 4'h0;
			s_next.oeN       = 1'b1;
			s_next.startSeen = 1'b1;
		end
		else if (stopCond)
		begin
			s_next.state = gauge_pkg::LS_IDLE;
			s_next.oeN   = 1'b1;
		end
		else
		begin
			case (s_reg.state)
				gauge_pkg::LS_ADDR, gauge_pkg::LS_WRITE:
				begin
					if (sclRise)
					begin
						s_next.shift = {s_reg.shift[6:0], sdaIn};
						s_next.cnt   = s_reg.cnt + 4'h1;
					end
					else if (sclFall && s_reg.cnt == gauge_pkg::BITS_PER_BYTE)
					begin
						s_next.oeN = 1'b0;
						if (s_reg.state == gauge_pkg::LS_WRITE)
						begin
							s_next.state   = gauge_pkg::LS_ACKW;
							s_next.wrByte  = 1'b1;
							s_next.wrFirst = s_reg.first;
							s_next.first   = 1'b0;
						end
						else if (s_reg.shift[7:1] == gauge_pkg::DEVICE_ADDR)
						begin
							s_next.state = gauge_pkg::LS_ACKA;
							s_next.rw    = s_reg.shift[0];
							s_next.first = 1'b1;
							s_next.rdReq = s_reg.shift[0];
						end
						else
						begin
							s_next.state = gauge_pkg::LS_IDLE;
							s_next.oeN   = 1'b1;
						end
					end
				end
				gauge_pkg::LS_ACKA, gauge_pkg::LS_ACKW:
				begin
					if (sclFall)
					begin
						s_next.cnt = 4'h0;
						s_next.oeN = 1'b1;
						s_next.state = gauge_pkg::LS_WRITE;
						if (s_reg.state == gauge_pkg::LS_ACKA && s_reg.rw)
						begin
							s_next.state = gauge_pkg::LS_READ;
							s_next.shift = bus.rdData;
							s_next.oeN   = bus.rdData[7];
							s_next.cnt   = 4'h1;
						end
					end
				end
				gauge_pkg::LS_READ:
				begin
					if (sclFall && s_reg.cnt == gauge_pkg::BITS_PER_BYTE)
					begin
						s_next.state = gauge_pkg::LS_RACK;
						s_next.oeN   = 1'b1;
					end
					else if (sclFall)
					begin
						s_next.shift = {s_reg.shift[6:0], 1'b0};
						s_next.oeN   = s_reg.shift[6];
						s_next.cnt   = s_reg.cnt + 4'h1;
					end
				end
				gauge_pkg::LS_RACK:
				begin
					// a master nack ends the read; the engine drops to idle at once
					if (sclRise && !sdaIn)
					begin
						s_next.rdReq = 1'b1;
						s_next.cnt   = 4'h0;
					end
					else if (sclRise)
						s_next.state = gauge_pkg::LS_IDLE;
					else if (sclFall && s_reg.cnt == 4'h0)
					begin
						s_next.state = gauge_pkg::LS_READ;
						s_next.shift = bus.rdData;
						s_next.oeN   = bus.rdData[7];
						s_next.cnt   = 4'h1;
					end
				end
				default:
					s_next.oeN = 1'b1;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
			s_reg <= '{state: gauge_pkg::LS_IDLE, sclQ: 1'b1, sdaQ: 1'b1, oeN: 1'b1, default: '0};
		else
			s_reg <= s_next;
	end

	assign sdaOut        = 1'b0;
	assign sdaOeN        = s_reg.oeN;
	assign bus.startSeen = s_reg.startSeen;
	assign bus.wrByte    = s_reg.wrByte;
	assign bus.wrFirst   = s_reg.wrFirst;
	assign bus.wrData    = s_reg.shift;
	assign bus.rdReq     = s_reg.rdReq;

	////////////////////////////////////////////////////////////////////////
	property p_foreign_addr;
		@(posedge sys_clk) disable iff (!rstN)
		(s_reg.state == gauge_pkg::LS_ADDR && sclFall && !startCond && !stopCond
			&& s_reg.cnt == gauge_pkg::BITS_PER_BYTE && s_reg.shift[7:1] != gauge_pkg::DEVICE_ADDR)
			|=> (s_reg.state == gauge_pkg::LS_IDLE && s_reg.oeN);
	endproperty
	a_foreign_addr: assert property (p_foreign_addr) else $error("foreign address acknowledged");

	property p_own_addr;
		@(posedge sys_clk) disable iff (!rstN)
		(s_reg.state == gauge_pkg::LS_ADDR && sclFall && !startCond && !stopCond
			&& s_reg.cnt == gauge_pkg::BITS_PER_BYTE && s_reg.shift[7:1] == gauge_pkg::DEVICE_ADDR)
			|=> (!s_reg.oeN && s_reg.state == gauge_pkg::LS_ACKA);
	endproperty
	a_own_addr: assert property (p_own_addr) else $error("own address not acknowledged");

endmodule : i2c_link

// file: logic/gauge_register_bank.sv
/*
 Top of the gauge register bank: 16-bit registers at byte pairs reached over
 the two-wire slave, read-clear interrupt status with active-low alert, and
 the quick-sense command strobe. Assumes the measurement core loads read-only
 words through measLoad and reports alert events as one-cycle pulses.
*/
// Functional notes
// - answer only the seven-bit slave address 1010101.
// - operate in fast mode, host stays at or below 400 kbit/s.
// - sensed current at 0x04 is read-only in mA, resets to zero.
// - thermal reading at 0x06 is read-only in 0.1 K, resets 0x0BA6.
// - cell voltage at 0x08 is read-only in mV, resets 0x0ED8.
// - remaining charge at 0x10 resets 0x03CF; full charge at 0x12 resets 0x079E.
// - time to empty at 0x16 is read-only minutes, resets 0xFFFF.
// - both tuning registers at 0x24, 0x26 are read-write, reset 0x3232.
// - cycle tally at 0x2A is read-write, resets to zero.
// - charge percent at 0x2C is read-only, resets 0x0021.
// - health percent at 0x2E is read-only, resets 0x0064.
// - extended control at 0x3E is read-write, resets zero.
// - mean voltage 0x64 resets 0x0ED8; mean thermal 0x66 resets 0x0BA6.
// - reading interrupt status clears it and releases alert; disabling enable does not.
// - writing 0x4000 to main control restarts voltage sensing and charge calculation.
`timescale 1ns/100ps
module gauge_register_bank (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        scl,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOeN,
	input  wire logic        measLoad,
	input  wire logic [6:0]  measAddr,
	input  wire logic [15:0] measData,
	input  wire logic [15:0] alertEvent,
	output logic             alertN,
	output logic             quickSense
);

	typedef struct packed {
		logic [gauge_pkg::WORD_COUNT-1:0][15:0] regs;
		logic [6:0]                             ptr;
		logic [7:0]                             lowLatch;
		logic [7:0]                             hiShadow;
		logic                                   shadowOk;
		logic [7:0]                             rdData;
		logic                                   alertN;
		logic                                   quickSense;
	} bank_t;

	bank_t        s_reg;
	bank_t        s_next;
	logic [1:0]   rstSync;
	logic         rstInt;
	gauge_link_if bus ();

	////////////////////////////////////////////////////////////////////////
	// decode helpers

	function automatic logic isMapped(input logic [6:0] a);
		logic [6:0] w;
		w = {a[6:1], 1'b0};
		if (w == gauge_pkg::A_MAIN_CONTROL || w == gauge_pkg::A_SENSED_AMP || w == gauge_pkg::A_THERMAL
			|| w == gauge_pkg::A_CELL_VOLTAGE || w == gauge_pkg::A_STATUS_ONE || w == gauge_pkg::A_STATUS_TWO
			|| w == gauge_pkg::A_REMAINING || w == gauge_pkg::A_FULL_CHARGE || w == gauge_pkg::A_MEAN_AMP
			|| w == gauge_pkg::A_TIME_TO_EMPTY || w == gauge_pkg::A_REVISION || w == gauge_pkg::A_TUNING_A
			|| w == gauge_pkg::A_TUNING_B || w == gauge_pkg::A_DIE_THERMAL || w == gauge_pkg::A_CYCLE_TALLY
			|| w == gauge_pkg::A_CHARGE_PCT || w == gauge_pkg::A_HEALTH_PCT || w == gauge_pkg::A_STATUS_THREE
			|| w == gauge_pkg::A_IRQ_STATUS || w == gauge_pkg::A_DESIGN_CAP || w == gauge_pkg::A_EXT_CONTROL
			|| w == gauge_pkg::A_MEAN_VOLTAGE || w == gauge_pkg::A_MEAN_THERMAL)
			return 1'b1;
		else
			return 1'b0;
	endfunction : isMapped

	function automatic logic isWritable(input logic [6:0] a);
		logic [6:0] w;
		w = {a[6:1], 1'b0};
		if (w == gauge_pkg::A_MAIN_CONTROL || w == gauge_pkg::A_TUNING_A || w == gauge_pkg::A_TUNING_B
			|| w == gauge_pkg::A_CYCLE_TALLY || w == gauge_pkg::A_EXT_CONTROL)
			return 1'b1;
		else
			return 1'b0;
	endfunction : isWritable

	function automatic logic [15:0] resetOf(input logic [6:0] a);
		logic [6:0] w;
		w = {a[6:1], 1'b0};
		if (w == gauge_pkg::A_THERMAL || w == gauge_pkg::A_DIE_THERMAL || w == gauge_pkg::A_MEAN_THERMAL)
			return gauge_pkg::R_THERMAL;
		else if (w == gauge_pkg::A_CELL_VOLTAGE || w == gauge_pkg::A_MEAN_VOLTAGE)
			return gauge_pkg::R_VOLTAGE;
		else if (w == gauge_pkg::A_REMAINING)
			return gauge_pkg::R_REMAINING;
		else if (w == gauge_pkg::A_FULL_CHARGE || w == gauge_pkg::A_DESIGN_CAP)
			return gauge_pkg::R_CAPACITY;
		else if (w == gauge_pkg::A_TIME_TO_EMPTY)
			return gauge_pkg::R_TIME_TO_EMPTY;
		else if (w == gauge_pkg::A_REVISION)
			return gauge_pkg::R_REVISION;
		else if (w == gauge_pkg::A_TUNING_A || w == gauge_pkg::A_TUNING_B)
			return gauge_pkg::R_TUNING;
		else if (w == gauge_pkg::A_CHARGE_PCT)
			return gauge_pkg::R_CHARGE_PCT;
		else if (w == gauge_pkg::A_HEALTH_PCT)
			return gauge_pkg::R_HEALTH_PCT;
		else
			return gauge_pkg::R_ZERO;
	endfunction : resetOf

	function automatic bank_t resetState();
		bank_t r;
		r = '0;
		for (int i = 0; i < gauge_pkg::WORD_COUNT; i++)
			r.regs[i] = resetOf({i[5:0], 1'b0});
		r.alertN = 1'b1;
		return r;
	endfunction : resetState

	////////////////////////////////////////////////////////////////////////
	// reset release and serial engine

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rstSync <= 2'h0;
		else
			rstSync <= {rstSync[0], 1'b1};
	end
	assign rstInt = rstSync[1];

	i2c_link u_link (
		.sys_clk (sys_clk),
		.rstN    (rstInt),
		.scl     (scl),
		.sdaIn   (sdaIn),
		.sdaOut  (sdaOut),
		.sdaOeN  (sdaOeN),
		.bus     (bus.link)
	);

	////////////////////////////////////////////////////////////////////////
	// register file

	always_comb
	begin
		logic [15:0] word;
		logic [15:0] irqCur;
		logic        irqClear;
		word              = '0;
		irqClear          = 1'b0;
		irqCur            = '0;
		s_next            = s_reg;
		s_next.quickSense = 1'b0;
		if (bus.startSeen)
			s_next.shadowOk = 1'b0;
		if (measLoad && isMapped(measAddr) && !isWritable(measAddr)
			&& {measAddr[6:1], 1'b0} != gauge_pkg::A_IRQ_STATUS)
			s_next.regs[measAddr[6:1]] = measData;
		if (bus.wrByte && bus.wrFirst)
		begin
			s_next.ptr      = bus.wrData[6:0];
			s_next.shadowOk = 1'b0;
		end
		else if (bus.wrByte)
		begin
			if (!s_reg.ptr[0])
				s_next.lowLatch = bus.wrData;
			else if (isWritable(s_reg.ptr))
			begin
				s_next.regs[s_reg.ptr[6:1]] = {bus.wrData, s_reg.lowLatch};
				if ({s_reg.ptr[6:1], 1'b0} == gauge_pkg::A_MAIN_CONTROL
					&& {bus.wrData, s_reg.lowLatch} == gauge_pkg::QUICK_SENSE_CMD)
					s_next.quickSense = 1'b1;
			end
			s_next.ptr = s_reg.ptr + 7'h01;
		end
		if (bus.rdReq)
		begin
			if (isMapped(s_reg.ptr))
				word = s_reg.regs[s_reg.ptr[6:1]];
			// the high byte comes from a snapshot so a word never tears
			if (!s_reg.ptr[0])
			begin
				s_next.rdData   = word[7:0];
				s_next.hiShadow = word[15:8];
				s_next.shadowOk = 1'b1;
				irqClear        = ({s_reg.ptr[6:1], 1'b0} == gauge_pkg::A_IRQ_STATUS);
			end
			else
			begin
				s_next.rdData   = s_reg.shadowOk ? s_reg.hiShadow : word[15:8];
				s_next.shadowOk = 1'b0;
			end
			s_next.ptr = s_reg.ptr + 7'h01;
		end
		// new events win over a read clear; enable gates only the setting
		irqCur = irqClear ? gauge_pkg::R_ZERO : s_reg.regs[gauge_pkg::A_IRQ_STATUS[6:1]];
		s_next.regs[gauge_pkg::A_IRQ_STATUS[6:1]] =
			irqCur | (alertEvent & s_reg.regs[gauge_pkg::A_EXT_CONTROL[6:1]]);
		s_next.alertN = ~(|s_next.regs[gauge_pkg::A_IRQ_STATUS[6:1]]);
	end

	always_ff @(posedge sys_clk or negedge rstInt)
	begin
		if (!rstInt)
			s_reg <= resetState();
		else
			s_reg <= s_next;
	end

	assign bus.rdData = s_reg.rdData;
	assign alertN     = s_reg.alertN;
	assign quickSense = s_reg.quickSense;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstInt);

	property p_ctl_reset;
		$rose(rstInt) |-> s_reg.regs[gauge_pkg::A_MAIN_CONTROL[6:1]] == gauge_pkg::R_ZERO;
	endproperty
	a_ctl_reset: assert property (p_ctl_reset) else $error("main control reset wrong");

	property p_amp_ro;
		!measLoad && !$past(measLoad) |-> $stable(s_reg.regs[gauge_pkg::A_SENSED_AMP[6:1]]);
	endproperty
	a_amp_ro: assert property (p_amp_ro) else $error("sensed current changed without load");

	property p_thermal_reset;
		$rose(rstInt) |-> s_reg.regs[gauge_pkg::A_THERMAL[6:1]] == 16'h0BA6
			&& s_reg.regs[gauge_pkg::A_MEAN_THERMAL[6:1]] == 16'h0BA6;
	endproperty
	a_thermal_reset: assert property (p_thermal_reset) else $error("thermal reset wrong");

	property p_volt_reset;
		$rose(rstInt) |-> s_reg.regs[gauge_pkg::A_CELL_VOLTAGE[6:1]] == 16'h0ED8
			&& s_reg.regs[gauge_pkg::A_MEAN_VOLTAGE[6:1]] == 16'h0ED8;
	endproperty
	a_volt_reset: assert property (p_volt_reset) else $error("voltage reset wrong");

	property p_cap_reset;
		$rose(rstInt) |-> s_reg.regs[gauge_pkg::A_REMAINING[6:1]] == 16'h03CF
			&& s_reg.regs[gauge_pkg::A_FULL_CHARGE[6:1]] == 16'h079E
			&& s_reg.regs[gauge_pkg::A_TIME_TO_EMPTY[6:1]] == 16'hFFFF;
	endproperty
	a_cap_reset: assert property (p_cap_reset) else $error("capacity reset wrong");

	property p_pct_reset;
		$rose(rstInt) |-> s_reg.regs[gauge_pkg::A_CHARGE_PCT[6:1]] == 16'h0021
			&& s_reg.regs[gauge_pkg::A_HEALTH_PCT[6:1]] == 16'h0064
			&& s_reg.regs[gauge_pkg::A_TUNING_A[6:1]] == 16'h3232;
	endproperty
	a_pct_reset: assert property (p_pct_reset) else $error("percent or tuning reset wrong");

	property p_rw_commit;
		bus.wrByte && !bus.wrFirst && s_reg.ptr[0] && {s_reg.ptr[6:1], 1'b0} == gauge_pkg::A_CYCLE_TALLY
			|=> s_reg.regs[gauge_pkg::A_CYCLE_TALLY[6:1]] == {$past(bus.wrData), $past(s_reg.lowLatch)};
	endproperty
	a_rw_commit: assert property (p_rw_commit) else $error("cycle tally write lost");

	property p_irq_host_ro;
		bus.wrByte && !bus.wrFirst && {s_reg.ptr[6:1], 1'b0} == gauge_pkg::A_IRQ_STATUS && alertEvent == '0
			|=> s_reg.regs[gauge_pkg::A_IRQ_STATUS[6:1]] == $past(s_reg.regs[gauge_pkg::A_IRQ_STATUS[6:1]]);
	endproperty
	a_irq_host_ro: assert property (p_irq_host_ro) else $error("host wrote interrupt status");

	property p_irq_clear;
		bus.rdReq && s_reg.ptr == gauge_pkg::A_IRQ_STATUS && alertEvent == '0 |=> alertN ##0
			s_reg.regs[gauge_pkg::A_IRQ_STATUS[6:1]] == gauge_pkg::R_ZERO;
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("interrupt read did not clear");

	property p_alert_hold;
		!alertN && !(bus.rdReq && s_reg.ptr == gauge_pkg::A_IRQ_STATUS) |=> !alertN;
	endproperty
	a_alert_hold: assert property (p_alert_hold) else $error("alert released without read");

	property p_quick_sense;
		bus.wrByte && !bus.wrFirst && s_reg.ptr == 7'h01 && {bus.wrData, s_reg.lowLatch} == 16'h4000
			|=> quickSense ##1 !quickSense;
	endproperty
	a_quick_sense: assert property (p_quick_sense) else $error("quick sense strobe missing");

	property p_ext_rw;
		bus.wrByte && !bus.wrFirst && s_reg.ptr == 7'h3F
			|=> s_reg.regs[gauge_pkg::A_EXT_CONTROL[6:1]] == {$past(bus.wrData), $past(s_reg.lowLatch)};
	endproperty
	a_ext_rw: assert property (p_ext_rw) else $error("extended control write lost");

	property p_ptr_step;
		(bus.rdReq || (bus.wrByte && !bus.wrFirst)) |=> s_reg.ptr == $past(s_reg.ptr) + 7'h01;
	endproperty
	a_ptr_step: assert property (p_ptr_step) else $error("byte address did not advance");

	c_quick: cover property (quickSense);
	c_irq_read: cover property (bus.rdReq && s_reg.ptr == gauge_pkg::A_IRQ_STATUS && !alertN);
	c_word_write: cover property (bus.wrByte && !bus.wrFirst && s_reg.ptr[0]);
	c_word_read: cover property (bus.rdReq && s_reg.ptr[0] && s_reg.shadowOk);

endmodule : gauge_register_bank

// file: tb/i2c_host_model.sv
/*
 Host model: the only bus master, open-drain sda with a pull-up.
 Assumes a 25 MHz sys_clk; the device's enable is low while it pulls sda.
*/
`timescale 1ns/100ps
module i2c_host_model (
	input  wire logic sys_clk,
	input  wire logic devOeN,
	output logic      scl,
	output logic      sda
);
	// 64 clocks a bit keeps the rate just under the fast-mode ceiling
	localparam int HALF = 31;
	logic hostOeN = 1'b1;
	initial scl = 1'b1;
	// released line floats to the pull-up level
	assign sda = hostOeN & devOeN;
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick
	// start is (1,0,0), stop is (0,1,1)
	task automatic cond(input logic a, input logic b, input logic c);
		hostOeN = a;
		tick(HALF);
		scl = 1'b1;
		tick(HALF);
		hostOeN = b;
		tick(HALF);
		scl = c;
		tick(2);
	endtask : cond
	task automatic bit_io(input logic b, output logic r);
		hostOeN = b;
		tick(HALF);
		scl = 1'b1;
		tick(HALF);
		r = sda;
		scl = 1'b0;
		tick(2);
	endtask : bit_io
	task automatic xfer(input logic [7:0] d, input logic ackOut, output logic [7:0] q, output logic ackIn);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(ackOut, ackIn);
	endtask : xfer
endmodule : i2c_host_model

// file: tb/gauge_i2c_register_map_test.sv
/*
 Bench for the gauge register bank: reset values, access kinds, slave
 address, quick sense and interrupt clearing. Assumes the host model.
*/
`timescale 1ns/100ps
module gauge_i2c_register_map_test;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        measLoad = 1'b0;
	logic [6:0]  measAddr = 7'h04;
	logic [15:0] measData = 16'h0123;
	logic [15:0] alertEvent = 16'h0000;
	logic        scl, sda, sdaOeN, alertN, quickSense, ack, sdaOutSeen;
	logic [7:0]  q;
	logic [15:0] w;
	logic [15:0] rb [4];
	int          badCount = 0;
	int          nTests = 0;
	int          qsCount = 0;
	localparam logic [6:0] RA [16] = '{7'h00, 7'h04, 7'h06, 7'h08, 7'h10, 7'h12, 7'h16, 7'h24,
		7'h26, 7'h2A, 7'h2C, 7'h2E, 7'h36, 7'h3E, 7'h64, 7'h66};
	localparam logic [15:0] RV [16] = '{16'h0000, 16'h0000, 16'h0BA6, 16'h0ED8, 16'h03CF, 16'h079E,
		16'hFFFF, 16'h3232, 16'h3232, 16'h0000, 16'h0021, 16'h0064, 16'h0000, 16'h0000, 16'h0ED8, 16'h0BA6};
	localparam logic [6:0] WA [6] = '{7'h00, 7'h24, 7'h2A, 7'h3E, 7'h04, 7'h2C};
	localparam logic [15:0] WD [6] = '{16'h1234, 16'hA55A, 16'h0102, 16'h8001, 16'hBEEF, 16'h1111};
	localparam logic [15:0] WE [6] = '{16'h1234, 16'hA55A, 16'h0102, 16'h8001, 16'h0000, 16'h0021};
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
		if (quickSense === 1'b1)
			qsCount++;
	gauge_register_bank dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .scl(scl), .sdaIn(sda), .sdaOut(sdaOutSeen),
		.sdaOeN(sdaOeN), .measLoad(measLoad), .measAddr(measAddr), .measData(measData),
		.alertEvent(alertEvent), .alertN(alertN), .quickSense(quickSense));
	i2c_host_model host_u (.sys_clk(sys_clk), .devOeN(sdaOeN), .scl(scl), .sda(sda));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		nTests++;
		if (seen !== exp)
		begin
			badCount++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic pulse(input logic [15:0] ev, input logic ld);
		alertEvent = ev;
		measLoad = ld;
		host_u.tick(1);
		alertEvent = 16'h0000;
		measLoad = 1'b0;
		host_u.tick(3);
	endtask : pulse
	task automatic head(input logic [6:0] a);
		host_u.cond(1'b1, 1'b0, 1'b0);
		host_u.xfer({gauge_pkg::DEVICE_ADDR, 1'b0}, 1'b1, q, ack);
		check({15'h0000, ack}, 16'h0000);
		host_u.xfer({1'b0, a}, 1'b1, q, ack);
	endtask : head
	task automatic wr_word(input logic [6:0] a, input logic [15:0] d);
		head(a);
		host_u.xfer(d[7:0], 1'b1, q, ack);
		host_u.xfer(d[15:8], 1'b1, q, ack);
		host_u.cond(1'b0, 1'b1, 1'b1);
	endtask : wr_word
	// n words in one transaction; the master nacks only the last byte
	task automatic rd_run(input logic [6:0] a, input int n);
		head(a);
		host_u.cond(1'b1, 1'b0, 1'b0);
		host_u.xfer({gauge_pkg::DEVICE_ADDR, 1'b1}, 1'b1, q, ack);
		for (int i = 0; i < 2 * n; i++)
		begin
			host_u.xfer(8'hFF, (i == 2 * n - 1) ? 1'b1 : 1'b0, q, ack);
			rb[i / 2][(i % 2) * 8 +: 8] = q;
		end
		host_u.cond(1'b0, 1'b1, 1'b1);
	endtask : rd_run
	task automatic rd_word(input logic [6:0] a, output logic [15:0] d);
		rd_run(a, 1);
		d = rb[0];
	endtask : rd_word
	task automatic chk_run(input int first, input int n);
		rd_run(RA[first], n);
		for (int k = 0; k < n; k++)
			check(rb[k], RV[first + k]);
	endtask : chk_run
	////////////////////////////////////////////////////////////////////////
	// neighbouring words share one burst, which keeps the run short at the bus rate
	task automatic t_reset();
		chk_run(0, 1);
		chk_run(1, 3);
		chk_run(4, 2);
		chk_run(6, 1);
		chk_run(7, 2);
		chk_run(9, 3);
		chk_run(12, 1);
		chk_run(13, 1);
		chk_run(14, 2);
	endtask : t_reset
	task automatic t_addr();
		host_u.cond(1'b1, 1'b0, 1'b0);
		host_u.xfer({7'h54, 1'b0}, 1'b1, q, ack);
		check({15'h0000, ack}, 16'h0001);
		check({15'h0000, sdaOutSeen}, 16'h0000);
		host_u.cond(1'b0, 1'b1, 1'b1);
	endtask : t_addr
	task automatic t_rw();
		for (int i = 0; i < 6; i++)
		begin
			wr_word(WA[i], WD[i]);
			rd_word(WA[i], w);
			check(w, WE[i]);
		end
		pulse(16'h0000, 1'b1);
		rd_word(7'h04, w);
		check(w, 16'h0123);
	endtask : t_rw
	task automatic t_quick();
		qsCount = 0;
		wr_word(7'h00, 16'h4001);
		check(16'(qsCount), 16'h0000);
		wr_word(7'h00, 16'h4000);
		check(16'(qsCount), 16'h0001);
	endtask : t_quick
	task automatic t_irq();
		pulse(16'h0002, 1'b0);
		check({15'h0000, alertN}, 16'h0001);
		pulse(16'h0001, 1'b0);
		check({15'h0000, alertN}, 16'h0000);
		wr_word(7'h3E, 16'h0000);
		check({15'h0000, alertN}, 16'h0000);
		wr_word(7'h36, 16'h0000);
		check({15'h0000, alertN}, 16'h0000);
		rd_word(7'h36, w);
		check(w, 16'h0001);
		check({15'h0000, alertN}, 16'h0001);
	endtask : t_irq
	task automatic endSim();
		$display("comparisons %0d mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : endSim
	initial
	begin
		repeat (12) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		host_u.tick(4);
		t_reset();
		t_addr();
		t_rw();
		t_quick();
		t_irq();
		endSim();
	end
	initial
	begin
		repeat (95000) @(posedge sys_clk);
		badCount++;
		endSim();
	end
endmodule : gauge_i2c_register_map_test
